// ---- rtl/vwr_pkg.sv ----
// constants shared by the vector watchpoint reporting block
package vwr_pkg;
   localparam int unsigned VWR_NUM_WP     = 16;
   localparam int unsigned VWR_AW         = 32;
   // register byte offsets
   localparam logic [11:0] VWR_OFF_ID     = 12'h000;
   localparam logic [11:0] VWR_OFF_CTRL   = 12'h010;
   localparam logic [11:0] VWR_OFF_WPEN   = 12'h014;
   localparam logic [11:0] VWR_OFF_HSTAT  = 12'h038;
   localparam logic [11:0] VWR_OFF_WADDR  = 12'h03c;
   localparam logic [3:0]  VWR_WP_REGION  = 4'h1;
   // syndrome field positions
   localparam int unsigned VWR_SYN_ISV    = 24;
   localparam int unsigned VWR_SYN_WPT_HI = 23;
   localparam int unsigned VWR_SYN_WPT_LO = 18;
   localparam int unsigned VWR_SYN_WATCH_INDEX_VALID   = 17;
   localparam int unsigned VWR_SYN_WPF    = 16;
   localparam int unsigned VWR_SYN_FNP    = 15;
   localparam int unsigned VWR_SYN_FNV    = 10;
   // feature id field
   localparam int unsigned VWR_ID_HSR_HI  = 7;
   localparam int unsigned VWR_ID_HSR_LO  = 4;
   localparam logic [3:0]  VWR_HSR_NONE   = 4'h0;
   localparam logic [3:0]  VWR_HSR_IMPL   = 4'h1;
   // control bits
   localparam int unsigned VWR_CTRL_EN    = 0;
   localparam int unsigned VWR_CTRL_HALT  = 1;
   localparam int unsigned VWR_CTRL_FNV   = 2;
   localparam int unsigned VWR_CTRL_WIDEN = 3;
   localparam logic [3:0]  VWR_CTRL_RST   = 4'h9;
   // widening granule of 16 bytes
   localparam logic [31:0] VWR_WIDEN_MASK = 32'h0000_000f;
endpackage

// ---- rtl/vwr_watch_report.sv ----
// vector watchpoint match and syndrome reporting with wishbone register slave
// Contract
// (R1) streaming accesses may fire when only the 16-byte widened range matches
// (R2) inactive predicated elements never fire a watchpoint event
// (R3) false positives allowed, a genuine original-range match always fires
// (R4) watchpoint index in bits 23:18, values 0 to 15, bit 24 reads zero
// (R5) bit 17 marks the watchpoint index as valid
// (R6) bit 16 set means only widened range matched, maybe false positive
// (R7) bit 15 address imprecise, forced zero when address invalid
// (R8) bit 10 address invalid, recorded address unknown when set
// (R9) feature id bits 7:4: 0 no halt status register, 1 implemented
// (R10) halt status register is read-only at offset 0x038
// (R11) halt status valid only while halted by a watchpoint event
// (R12) halt status shares syndrome field layout and qualifies watch address
// (R13) recorded address lies in accessed range and is a watchpointed address; with bit 16 set the code records a widened-range address instead
// (R14) false-positive flag set when watched address was not accessed, else zero
// (R15) address invalid only for streaming accesses, zero for all others
// (R16) imprecise set when lowest watched address at or above recorded is unaccessed
// (R17) index valid set whenever invalid, imprecise or false-positive is set
// (R18) index valid set means index field holds the triggering watchpoint
// (R19) with several matches any one matching index may be reported
// (R20) halt status reads have no side effect, writes are ignored
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
module vwr_watch_report
   import vwr_pkg::*;
#(
   parameter int unsigned NUM_WP      = VWR_NUM_WP,
   parameter int unsigned AW          = VWR_AW,
   parameter bit          HSR_PRESENT = 1'b1
)
(
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          ce_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [11:0]   wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          acc_valid_i,
   input  wire logic          acc_active_i,
   input  wire logic          acc_stream_i,
   input  wire logic [AW-1:0] acc_lo_i,
   input  wire logic [AW-1:0] acc_hi_i,
   input  wire logic          debug_exit_i,
   output logic               watch_event_o,
   output logic               exc_valid_o,
   output logic      [63:0]   exc_syndrome_o,
   output logic      [AW-1:0] fault_address_o,
   output logic               debug_halted_o
);

   typedef struct packed {
      logic                         ack;
      logic [31:0]                  rdata;
      logic [3:0]                   ctrl;
      logic [15:0]                  wp_en;
      logic [NUM_WP-1:0][AW-1:0]    wp_lo;
      logic [NUM_WP-1:0][AW-1:0]    wp_hi;
      logic                         event_p;
      logic                         exc_p;
      logic [63:0]                  syndrome;
      logic [AW-1:0]                fault_addr;
      logic                         halted;
      logic [31:0]                  halt_status;
      logic [AW-1:0]                watch_addr;
   } vwr_state_type;

   localparam vwr_state_type ST_RST = '{ctrl: VWR_CTRL_RST, default: '0};

   vwr_state_type          s_r;
   vwr_state_type          s_nxt;
   logic [NUM_WP-1:0]      orig_hit;
   logic [NUM_WP-1:0]      wide_hit;
   logic [AW-1:0]          wide_lo;
   logic [AW-1:0]          wide_hi;
   logic                   wide_ok;
   logic                   take_ok;
   logic                   fire;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            r[8*b +: 8] = din[8*b +: 8];
      end
      return r;
   endfunction

   // widening is only legal for streaming contiguous or matrix accesses
   assign wide_ok = acc_stream_i & s_r.ctrl[VWR_CTRL_WIDEN]; // R1
   assign wide_lo = acc_lo_i & ~AW'(VWR_WIDEN_MASK);
   assign wide_hi = acc_hi_i | AW'(VWR_WIDEN_MASK);
   // accesses are ignored while halted: the core issues none in debug state
   assign take_ok = s_r.ctrl[VWR_CTRL_EN] & acc_valid_i & acc_active_i & ~s_r.halted; // R2
   assign fire    = take_ok & ((|orig_hit) | (|wide_hit)); // R3

   genvar gi;
   generate
      for (gi = 0; gi < NUM_WP; gi++)
      begin : g_wp
         assign orig_hit[gi] = s_r.wp_en[gi] & (acc_lo_i <= s_r.wp_hi[gi]) & (acc_hi_i >= s_r.wp_lo[gi]);
         assign wide_hit[gi] = s_r.wp_en[gi] & wide_ok & (wide_lo <= s_r.wp_hi[gi]) & (wide_hi >= s_r.wp_lo[gi]);
      end
   endgenerate

   always_comb
   begin
      logic [3:0]    idx;
      logic          maybe_false_positive;
      logic          address_invalid;
      logic          address_imprecise;
      logic          watch_index_valid;
      logic [AW-1:0] base_lo;
      logic [AW-1:0] rec;
      logic [63:0]   syn;
      logic [3:0]    ent;
      logic          rd_en;
      logic          wr_en;
      logic [31:0]   rd;
      idx     = 4'h0;
      maybe_false_positive     = 1'b0;
      address_invalid     = 1'b0;
      address_imprecise     = 1'b0;
      watch_index_valid    = 1'b0;
      base_lo = '0;
      rec     = '0;
      syn     = '0;
      ent     = wb_adr_i[6:3];
      rd_en   = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
      rd      = '0;
      s_nxt   = s_r;

      // pick the lowest widened match, then let the lowest original match override
      for (int i = NUM_WP - 1; i >= 0; i--)
      begin
         if (wide_hit[i])
            idx = 4'(i); // R19
      end
      for (int i = NUM_WP - 1; i >= 0; i--)
      begin
         if (orig_hit[i])
            idx = 4'(i); // R19
      end
      maybe_false_positive     = ~(|orig_hit); // R6 R14
      address_invalid     = acc_stream_i & s_r.ctrl[VWR_CTRL_FNV]; // R15 R8
      // recorded address is itself watched, so only an unaccessed widened address is imprecise
      address_imprecise     = maybe_false_positive & ~address_invalid; // R16 R7
      watch_index_valid    = 1'b1; // R17 R5
      base_lo = maybe_false_positive ? wide_lo : acc_lo_i;
      rec     = (base_lo > s_r.wp_lo[idx]) ? base_lo : s_r.wp_lo[idx]; // R13
      syn[VWR_SYN_WPT_HI:VWR_SYN_WPT_LO] = {2'b00, idx}; // R4 R18
      syn[VWR_SYN_ISV]  = 1'b0; // R4
      syn[VWR_SYN_WATCH_INDEX_VALID] = watch_index_valid;
      syn[VWR_SYN_WPF]  = maybe_false_positive;
      syn[VWR_SYN_FNP]  = address_imprecise;
      syn[VWR_SYN_FNV]  = address_invalid;

      s_nxt.event_p = fire;
      s_nxt.exc_p   = fire & ~s_r.ctrl[VWR_CTRL_HALT];
      if (fire & ~s_r.ctrl[VWR_CTRL_HALT])
      begin
         s_nxt.syndrome   = syn;
         s_nxt.fault_addr = rec;
      end
      if (debug_exit_i)
         s_nxt.halted = 1'b0;
      // a halt entry in the same cycle as an exit request wins
      if (fire & s_r.ctrl[VWR_CTRL_HALT])
      begin
         s_nxt.halted      = 1'b1;
         s_nxt.halt_status = HSR_PRESENT ? syn[31:0] : 32'h0000_0000; // R12
         s_nxt.watch_addr  = rec; // R12
      end

      // registers: ack one cycle after the strobe, write lands at the acked edge
      s_nxt.ack = rd_en;
      if (wb_adr_i[11:8] == VWR_WP_REGION)
      begin
         if (!wb_adr_i[7] && (32'(ent) < NUM_WP))
            rd = wb_adr_i[2] ? 32'(s_r.wp_hi[ent]) : 32'(s_r.wp_lo[ent]);
      end
      else
      begin
         unique case ({wb_adr_i[7:2], 2'b00})
            VWR_OFF_ID[7:0]:
            begin
               rd[VWR_ID_HSR_HI:VWR_ID_HSR_LO] = HSR_PRESENT ? VWR_HSR_IMPL : VWR_HSR_NONE; // R9
            end
            VWR_OFF_CTRL[7:0]: rd[3:0] = s_r.ctrl;
            VWR_OFF_WPEN[7:0]: rd[15:0] = s_r.wp_en;
            // outside a watchpoint halt the content is unspecified; zero is shown
            VWR_OFF_HSTAT[7:0]: rd = s_r.halted ? s_r.halt_status : 32'h0000_0000; // R10 R11
            VWR_OFF_WADDR[7:0]: rd = s_r.halted ? 32'(s_r.watch_addr) : 32'h0000_0000;
            default: rd = 32'h0000_0000;
         endcase
         if (wb_adr_i[11:8] != 4'h0)
            rd = 32'h0000_0000;
      end
      if (rd_en)
         s_nxt.rdata = rd;

      // halt status and watch address have no write path
      if (wr_en)
      begin
         if (wb_adr_i[11:8] == VWR_WP_REGION)
         begin
            if (!wb_adr_i[7] && (32'(ent) < NUM_WP))
            begin
               if (wb_adr_i[2])
                  s_nxt.wp_hi[ent] = AW'(wmerge(32'(s_r.wp_hi[ent]), wb_dat_i, wb_sel_i));
               else
                  s_nxt.wp_lo[ent] = AW'(wmerge(32'(s_r.wp_lo[ent]), wb_dat_i, wb_sel_i));
            end
         end
         else if ({wb_adr_i[11:2], 2'b00} == VWR_OFF_CTRL)
            s_nxt.ctrl = 4'(wmerge(32'(s_r.ctrl), wb_dat_i, wb_sel_i));
         else if ({wb_adr_i[11:2], 2'b00} == VWR_OFF_WPEN)
            s_nxt.wp_en = 16'(wmerge(32'(s_r.wp_en), wb_dat_i, wb_sel_i));
      end // R20
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s_r <= ST_RST; // R12
      else if (ce_i)
         s_r <= s_nxt;
   end

   assign wb_ack_o        = s_r.ack;
   assign wb_dat_o        = s_r.rdata;
   assign watch_event_o   = s_r.event_p;
   assign exc_valid_o     = s_r.exc_p;
   assign exc_syndrome_o  = s_r.syndrome;
   assign fault_address_o = s_r.fault_addr;
   assign debug_halted_o  = s_r.halted;

   chk_inactive_silent: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
      $past(ce_i) && $past(acc_valid_i) && !$past(acc_active_i) |-> !watch_event_o)
      else $error("inactive element fired a watchpoint");
   chk_no_false_neg: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      $past(ce_i) && $past(take_ok) && $past(|orig_hit) |-> watch_event_o)
      else $error("genuine watchpoint match missed");
   chk_index_field: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
      exc_valid_o |-> exc_syndrome_o[VWR_SYN_WPT_HI:VWR_SYN_WPT_HI-1] == 2'b00 && !exc_syndrome_o[VWR_SYN_ISV])
      else $error("watch index field out of range");
   chk_valid_implied: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R17
      exc_valid_o && (exc_syndrome_o[VWR_SYN_FNV] || exc_syndrome_o[VWR_SYN_FNP] || exc_syndrome_o[VWR_SYN_WPF])
      |-> exc_syndrome_o[VWR_SYN_WATCH_INDEX_VALID])
      else $error("index valid missing");
   chk_fnp_masked: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      exc_syndrome_o[VWR_SYN_FNV] |-> !exc_syndrome_o[VWR_SYN_FNP])
      else $error("imprecise set with invalid address");
   chk_fnv_nonstream: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
      $past(ce_i) && exc_valid_o && !$past(acc_stream_i) |-> !exc_syndrome_o[VWR_SYN_FNV])
      else $error("address invalid on non-streaming access");
   chk_wpf_orig: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R14
      $past(ce_i) && exc_valid_o && $past(|orig_hit) |-> !exc_syndrome_o[VWR_SYN_WPF])
      else $error("false positive flagged on original match");
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
   chk_status_held: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
      debug_halted_o && $past(debug_halted_o) |-> $stable(s_r.halt_status) && $stable(s_r.watch_addr))
      else $error("halt status changed while halted");
   chk_status_ro: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R20
      ce_i && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[11:2] == VWR_OFF_HSTAT[11:2] && !fire
      |=> $stable(s_r.halt_status))
      else $error("write reached halt status");
   // event side checks, looked at one edge after the access is taken
   chk_exc_has_event: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      exc_valid_o |-> watch_event_o)
      else $error("exception without watchpoint event");
   chk_index_valid: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
      exc_valid_o |-> exc_syndrome_o[VWR_SYN_WATCH_INDEX_VALID])
      else $error("index valid clear on exception");
   chk_widen_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      $past(ce_i) && $past(take_ok) && !$past(acc_stream_i) && !$past(|orig_hit) |-> !watch_event_o)
      else $error("widened match fired on a non-streaming access");
   chk_halt_entry: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
      $past(ce_i) && $past(fire) && $past(s_r.ctrl[VWR_CTRL_HALT]) |-> debug_halted_o && !exc_valid_o)
      else $error("halt route did not enter debug state");
   chk_halt_fnp_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
      debug_halted_o && s_r.halt_status[VWR_SYN_FNV] |-> !s_r.halt_status[VWR_SYN_FNP])
      else $error("halt status imprecise set with invalid address");
   chk_halt_isv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
      debug_halted_o |-> !s_r.halt_status[VWR_SYN_ISV] && s_r.halt_status[VWR_SYN_WPT_HI:VWR_SYN_WPT_HI-1] == 2'b00)
      else $error("halt status index field out of range");
   chk_fault_range: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
      $past(ce_i) && exc_valid_o && !exc_syndrome_o[VWR_SYN_WPF]
      |-> fault_address_o >= $past(acc_lo_i) && fault_address_o <= $past(acc_hi_i))
      else $error("fault address outside the access");
   chk_ack_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(ce_i) && $past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> wb_ack_o)
      else $error("register request not acknowledged");
endmodule

// ---- verification/vwr_handler_model.sv ----
// exception handler model that captures the syndrome and fault address on every exception
`timescale 1ns/10ps
module vwr_handler_model
   import vwr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        exc_valid_i,
   input  wire logic [63:0] syn_i,
   input  wire logic [31:0] addr_i,
   output logic      [63:0] syn_o,
   output logic      [31:0] addr_o,
   output logic      [7:0]  n_exc_o
);
   // taken on the pulse itself, it stands one cycle only
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         syn_o   <= 64'h0;
         addr_o  <= 32'h0;
         n_exc_o <= 8'h0;
      end
      else if (exc_valid_i)
      begin
         syn_o   <= syn_i;
         addr_o  <= addr_i;
         n_exc_o <= n_exc_o + 8'h1;
      end
   end
endmodule

// ---- verification/tb.sv ----
// register and access sequences for the watchpoint reporting block
`timescale 1ns/10ps
module tb
   import vwr_pkg::*;
;
   logic clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, acc_valid_i, acc_active_i, acc_stream_i;
   logic debug_exit_i, watch_event_o, exc_valid_o, debug_halted_o;
   logic [11:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, acc_lo_i, acc_hi_i, fault_address_o, m_addr;
   logic [63:0] exc_syndrome_o, m_syn;
   logic [7:0]  m_n;
   int          n_errors = 0;
   int          checks = 0;
   int          cycles = 0;
   vwr_watch_report i_vwr_watch_report (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .acc_valid_i(acc_valid_i), .acc_active_i(acc_active_i), .acc_stream_i(acc_stream_i),
      .acc_lo_i(acc_lo_i), .acc_hi_i(acc_hi_i), .debug_exit_i(debug_exit_i),
      .watch_event_o(watch_event_o), .exc_valid_o(exc_valid_o), .exc_syndrome_o(exc_syndrome_o),
      .fault_address_o(fault_address_o), .debug_halted_o(debug_halted_o));
   vwr_handler_model i_vwr_handler_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .exc_valid_i(exc_valid_o),
      .syn_i(exc_syndrome_o), .addr_i(fault_address_o), .syn_o(m_syn), .addr_o(m_addr), .n_exc_o(m_n));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic final_report;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   // request held until ack is sampled high, then released for at least one cycle
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, wd, 4'hf};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
         n_errors++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] d;
      wb(1'b1, a, v, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      wb(1'b0, a, 32'h0, d);
      chk_val("rdata", {32'h0, e}, {32'h0, d & m});
   endtask
   function automatic logic [63:0] syn(input logic [5:0] w, input logic f, input logic p, input logic v);
      syn = 64'h0;
      syn[VWR_SYN_WPT_HI:VWR_SYN_WPT_LO] = w;
      syn[VWR_SYN_WATCH_INDEX_VALID] = 1'b1;
      syn[VWR_SYN_WPF] = f;
      syn[VWR_SYN_FNP] = p;
      syn[VWR_SYN_FNV] = v;
   endfunction
   // one access, then the event and exception pulses are looked at in their own cycle
   task automatic acc(input logic s, input logic act, input logic [31:0] lo, input logic [31:0] hi,
                      input logic ev, input logic ex);
      @(posedge clk_i);
      {acc_valid_i, acc_active_i, acc_stream_i, acc_lo_i, acc_hi_i} <= {1'b1, act, s, lo, hi};
      @(posedge clk_i);
      acc_valid_i <= 1'b0;
      @(negedge clk_i);
      chk_flag("event", ev, watch_event_o);
      chk_flag("exception", ex, exc_valid_o);
   endtask
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {acc_valid_i, acc_active_i, acc_stream_i, acc_lo_i, acc_hi_i, debug_exit_i} = '0;
      rst_b_i = 1'b0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rdc(VWR_OFF_ID, 32'hf0, {24'h0, VWR_HSR_IMPL, 4'h0});
      rdc(VWR_OFF_HSTAT, 32'hffffffff, 32'h0);
      wr(12'h100, 32'h1000);
      wr(12'h104, 32'h1003);
      wr(12'h118, 32'h2008);
      wr(12'h11c, 32'h200b);
      wr(VWR_OFF_WPEN, 32'h9);
      acc(1'b0, 1'b1, 32'h1002, 32'h1005, 1'b1, 1'b1);
      chk_val("syndrome", syn(6'd0, 1'b0, 1'b0, 1'b0), exc_syndrome_o);
      chk_val("fault address", 64'h1002, {32'h0, fault_address_o});
      acc(1'b1, 1'b1, 32'h2000, 32'h2003, 1'b1, 1'b1);
      chk_val("syndrome", syn(6'd3, 1'b1, 1'b1, 1'b0), exc_syndrome_o);
      chk_val("fault address", 64'h2008, {32'h0, fault_address_o});
      acc(1'b0, 1'b1, 32'h2000, 32'h2003, 1'b0, 1'b0);
      acc(1'b1, 1'b0, 32'h2000, 32'h2003, 1'b0, 1'b0);
      acc(1'b1, 1'b0, 32'h1000, 32'h1000, 1'b0, 1'b0);
      wr(VWR_OFF_CTRL, 32'hd);
      acc(1'b1, 1'b1, 32'h0ff8, 32'h1001, 1'b1, 1'b1);
      chk_val("syndrome", syn(6'd0, 1'b0, 1'b0, 1'b1), exc_syndrome_o);
      @(negedge clk_i);
      chk_val("handler syndrome", syn(6'd0, 1'b0, 1'b0, 1'b1), m_syn);
      chk_val("handler count", 64'h3, {56'h0, m_n});
      chk_val("handler address", 64'h1000, {32'h0, m_addr});
      wr(VWR_OFF_CTRL, 32'hb);
      acc(1'b0, 1'b1, 32'h2009, 32'h2009, 1'b1, 1'b0);
      chk_flag("halted", 1'b1, debug_halted_o);
      rdc(VWR_OFF_HSTAT, 32'hffffffff, 32'(syn(6'd3, 1'b0, 1'b0, 1'b0)));
      rdc(VWR_OFF_WADDR, 32'hffffffff, 32'h2009);
      wr(VWR_OFF_HSTAT, 32'h0);
      rdc(VWR_OFF_HSTAT, 32'hffffffff, 32'(syn(6'd3, 1'b0, 1'b0, 1'b0)));
      acc(1'b0, 1'b1, 32'h1000, 32'h1000, 1'b0, 1'b0);
      @(posedge clk_i);
      debug_exit_i <= 1'b1;
      @(posedge clk_i);
      debug_exit_i <= 1'b0;
      @(negedge clk_i);
      chk_flag("halted", 1'b0, debug_halted_o);
      rdc(VWR_OFF_HSTAT, 32'hffffffff, 32'h0);
      final_report();
   end
endmodule
